// ---- logic/axrj_defines.vh ----
// Purpose: Shared constants for the accumulator logic, rotate and jump datapath.
// Assumes: Opcodes are 8-bit words read as three octal digits of 2, 3 and 3 bits.
// Notes: Definitions only; included by the core and the ALU.
//
// Contract
// - Exclusive-or sets an accumulator bit only when exactly one input bit is one.
// - Octal 250 to 256 exclusive-or the accumulator with a register by low digit.
// - Octal 257 exclusive-ors the accumulator with memory at page and offset pointers.
// - Octal 054 exclusive-ors with the next word; counter also steps past it.
// - Operand register stays unchanged; accumulator with itself always gives zero.
// - AND or OR of the accumulator with itself keeps its value.
// - Octal 002 rotates left circular; carry takes the old top bit.
// - Octal 022 rotates left through carry; old carry enters bit zero.
// - Octal 012 rotates right circular; old bit zero enters the top bit.
// - Octal 032 rotates right through carry; old carry enters the top bit.
// - Rotates change only the carry flag.
// - The program counter steps by one after the opcode, an immediate word and a jump's low address word.
// - A jump takes three words: opcode, then two address words.
// - A jump loads the assembled target and fetching continues from there.
// - Jump opcode is octal 1x4 whatever the middle digit.
// - Every logic instruction clears carry and sets other flags from the result.

`ifndef AXRJ_DEFINES_VH
`define AXRJ_DEFINES_VH

`define AXRJ_PAGE_W 6
`define AXRJ_RST_BYTE 8'h00
`define AXRJ_RST_BIT 1'b0

`define AXRJ_GRP_REG 2'h2
`define AXRJ_GRP_IMM 2'h0
`define AXRJ_GRP_JMP 2'h1
`define AXRJ_SRC_MEM 3'h7
`define AXRJ_SRC_IMM 3'h4
`define AXRJ_SRC_ROT 3'h2
`define AXRJ_SRC_JMP 3'h4
`define AXRJ_ROT_TOP 3'h0

`define AXRJ_ALU_RLC 3'h0
`define AXRJ_ALU_RRC 3'h1
`define AXRJ_ALU_RAL 3'h2
`define AXRJ_ALU_RAR 3'h3
`define AXRJ_ALU_AND 3'h4
`define AXRJ_ALU_XOR 3'h5
`define AXRJ_ALU_OR 3'h6

`define AXRJ_IDX_ACC 3'h0
`define AXRJ_IDX_PAGE 3'h5
`define AXRJ_IDX_OFS 3'h6
`define AXRJ_NUM_REGS 7

`endif

// ---- logic/axrj_alu.v ----
// Purpose: Combinational logic and rotate unit for the accumulator.
// Assumes: Operation codes follow the shared defines.
// Notes: Condition flags other than carry are judged by the caller from upd_zsp.
`timescale 1ns/1ps
`include "axrj_defines.vh"
module axrj_alu
(
	input wire [2:0] op,
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	output reg [7:0] res,
	output reg cout,
	output reg upd_zsp
);
	always @*
	begin
		res = a;
		cout = cin;
		upd_zsp = 1'b0;
		case (op)
			`AXRJ_ALU_AND:
			begin
				res = a & b;
				cout = 1'b0;
				upd_zsp = 1'b1;
			end
			`AXRJ_ALU_XOR:
			begin
				res = a ^ b;
				cout = 1'b0;
				upd_zsp = 1'b1;
			end
			`AXRJ_ALU_OR:
			begin
				res = a | b;
				cout = 1'b0;
				upd_zsp = 1'b1;
			end
			`AXRJ_ALU_RLC:
			begin
				res = {a[6:0], a[7]};
				cout = a[7];
			end
			`AXRJ_ALU_RRC:
			begin
				res = {a[0], a[7:1]};
				cout = a[0];
			end
			`AXRJ_ALU_RAL:
			begin
				res = {a[6:0], cin};
				cout = a[7];
			end
			`AXRJ_ALU_RAR:
			begin
				res = {cin, a[7:1]};
				cout = a[0];
			end
			default:
			begin
				res = a;
				cout = cin;
				upd_zsp = 1'b0;
			end
		endcase
	end
endmodule

// ---- logic/axrj_core.v ----
// Purpose: Fetch, decode and execute for logic, rotate and jump instructions.
// Assumes: Memory runs on CLK_SYS and answers a held request with a one-cycle ack.
// Notes: Opcodes outside the covered groups are fetched and passed over as one word.
`timescale 1ns/1ps
`include "axrj_defines.vh"
module axrj_core #(
	parameter PAGE_W = `AXRJ_PAGE_W
)
(
	input wire CLK_SYS,
	input wire NRST,
	input wire [7:0] MEM_RDATA,
	input wire MEM_ACK,
	input wire REG_WR_EN,
	input wire [2:0] REG_WR_SEL,
	input wire [7:0] REG_WR_DATA,
	output wire MEM_REQ,
	output wire [PAGE_W+7:0] MEM_ADDR,
	output wire [PAGE_W+7:0] PC,
	output wire [7:0] ACC,
	output wire FLAG_CARRY,
	output wire FLAG_ZERO,
	output wire FLAG_SIGN,
	output wire FLAG_PARITY,
	output wire INSTR_DONE
);
	localparam AW = PAGE_W + 8;
	localparam [2:0] ST_FETCH = 3'h0;
	localparam [2:0] ST_DECODE = 3'h1;
	localparam [2:0] ST_OPND = 3'h2;
	localparam [2:0] ST_JLO = 3'h3;
	localparam [2:0] ST_JHI = 3'h4;
	localparam [AW-1:0] PC_ONE = {{(AW-1){1'b0}}, 1'b1};

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [7:0] ir_ff;
	reg [7:0] nxt_ir;
	reg [AW-1:0] pc_ff;
	reg [AW-1:0] nxt_pc;
	reg [AW-1:0] addr_ff;
	reg [AW-1:0] nxt_addr;
	reg mem_req_ff;
	reg nxt_mem_req;
	reg [7:0] jlo_ff;
	reg [7:0] nxt_jlo;
	reg carry_ff;
	reg nxt_carry;
	reg zero_ff;
	reg nxt_zero;
	reg sign_ff;
	reg nxt_sign;
	reg parity_ff;
	reg nxt_parity;
	reg done_ff;
	reg nxt_done;
	reg acc_we;
	reg [7:0] acc_wdata;
	reg [7:0] rf_ff [0:`AXRJ_NUM_REGS-1];

	wire [7:0] alu_res;
	wire alu_cout;
	wire alu_upd;
	wire [2:0] alu_op;
	wire [7:0] alu_b;
	wire [7:0] reg_opnd;
	wire logic_op;
	wire is_logic_reg;
	wire is_logic_mem;
	wire is_logic_imm;
	wire is_rot;
	wire is_jmp;
	wire mem_done;
	wire res_zero;
	wire res_sign;
	wire res_parity;

	// Octal digits of the held opcode are its 2, 3 and 3 bit fields.
	assign logic_op = ir_ff[5] && (ir_ff[5:3] != 3'h7);
	assign is_logic_reg = (ir_ff[7:6] == `AXRJ_GRP_REG) && logic_op
		&& (ir_ff[2:0] != `AXRJ_SRC_MEM);
	assign is_logic_mem = (ir_ff[7:6] == `AXRJ_GRP_REG) && logic_op
		&& (ir_ff[2:0] == `AXRJ_SRC_MEM);
	assign is_logic_imm = (ir_ff[7:6] == `AXRJ_GRP_IMM) && logic_op
		&& (ir_ff[2:0] == `AXRJ_SRC_IMM);
	assign is_rot = (ir_ff[7:5] == `AXRJ_ROT_TOP)
		&& (ir_ff[2:0] == `AXRJ_SRC_ROT);
	// The middle digit is ignored so every 1x4 form jumps.
	assign is_jmp = (ir_ff[7:6] == `AXRJ_GRP_JMP)
		&& (ir_ff[2:0] == `AXRJ_SRC_JMP);

	assign reg_opnd = rf_ff[ir_ff[2:0]];
	assign alu_op = is_rot ? {1'b0, ir_ff[4:3]} : ir_ff[5:3];
	assign alu_b = (state_ff == ST_OPND) ? MEM_RDATA : reg_opnd;
	assign mem_done = mem_req_ff && MEM_ACK;

	// Result flags are shared by register and operand paths so both judge alike.
	assign res_zero = (alu_res == 8'h00);
	assign res_sign = alu_res[7];
	assign res_parity = ~^alu_res;

	axrj_alu u_alu
	(
		.op(alu_op),
		.a(rf_ff[`AXRJ_IDX_ACC]),
		.b(alu_b),
		.cin(carry_ff),
		.res(alu_res),
		.cout(alu_cout),
		.upd_zsp(alu_upd)
	);

	// Register and rotate results are written at the end of decode, operand results on the ack in ST_OPND, so done rises with the new accumulator.
	always @*
	begin
		nxt_state = state_ff;
		nxt_ir = ir_ff;
		nxt_pc = pc_ff;
		nxt_addr = addr_ff;
		nxt_mem_req = mem_req_ff;
		nxt_jlo = jlo_ff;
		nxt_carry = carry_ff;
		nxt_zero = zero_ff;
		nxt_sign = sign_ff;
		nxt_parity = parity_ff;
		nxt_done = 1'b0;
		acc_we = 1'b0;
		acc_wdata = alu_res;
		case (state_ff)
			ST_FETCH:
			begin
				nxt_mem_req = 1'b1;
				if (mem_done)
				begin
					nxt_ir = MEM_RDATA;
					nxt_pc = pc_ff + PC_ONE;
					nxt_mem_req = 1'b0;
					nxt_state = ST_DECODE;
				end
			end
			ST_DECODE:
			begin
				nxt_mem_req = 1'b1;
				nxt_addr = pc_ff;
				nxt_state = ST_FETCH;
				if (is_logic_reg || is_rot)
				begin
					acc_we = 1'b1;
					nxt_done = 1'b1;
					nxt_carry = alu_cout;
				end
				else if (is_logic_mem)
				begin
					// Data pointer is page register over offset register.
					nxt_addr = {rf_ff[`AXRJ_IDX_PAGE][PAGE_W-1:0],
						rf_ff[`AXRJ_IDX_OFS]};
					nxt_state = ST_OPND;
				end
				else if (is_logic_imm)
				begin
					nxt_state = ST_OPND;
				end
				else if (is_jmp)
				begin
					nxt_state = ST_JLO;
				end
				else
				begin
					nxt_done = 1'b1;
				end
				if (alu_upd && (is_logic_reg || is_rot))
				begin
					nxt_zero = res_zero;
					nxt_sign = res_sign;
					nxt_parity = res_parity;
				end
			end
			ST_OPND:
			begin
				if (mem_done)
				begin
					acc_we = 1'b1;
					nxt_carry = alu_cout;
					nxt_zero = res_zero;
					nxt_sign = res_sign;
					nxt_parity = res_parity;
					nxt_done = 1'b1;
					if (is_logic_imm)
					begin
						// Step past the immediate word before the next fetch.
						nxt_pc = pc_ff + PC_ONE;
						nxt_addr = pc_ff + PC_ONE;
					end
					else
					begin
						nxt_addr = pc_ff;
					end
					nxt_state = ST_FETCH;
				end
			end
			ST_JLO:
			begin
				// The low target half is held until the page half arrives.
				if (mem_done)
				begin
					nxt_jlo = MEM_RDATA;
					nxt_pc = pc_ff + PC_ONE;
					nxt_addr = pc_ff + PC_ONE;
					nxt_state = ST_JHI;
				end
			end
			ST_JHI:
			begin
				if (mem_done)
				begin
					// Only the low page bits fit the address; the rest are dropped.
					nxt_pc = {MEM_RDATA[PAGE_W-1:0], jlo_ff};
					nxt_addr = {MEM_RDATA[PAGE_W-1:0], jlo_ff};
					nxt_done = 1'b1;
					nxt_state = ST_FETCH;
				end
			end
			default:
			begin
				// An illegal state falls back to a fetch at the counter.
				nxt_state = ST_FETCH;
				nxt_addr = pc_ff;
				nxt_mem_req = 1'b0;
			end
		endcase
	end

	// Synchronous reset keeps the state and flags in step with the memory side.
	always @(posedge CLK_SYS)
	begin
		if (!NRST)
		begin
			state_ff <= ST_FETCH;
			ir_ff <= `AXRJ_RST_BYTE;
			pc_ff <= {AW{1'b0}};
			addr_ff <= {AW{1'b0}};
			mem_req_ff <= `AXRJ_RST_BIT;
			jlo_ff <= `AXRJ_RST_BYTE;
			carry_ff <= `AXRJ_RST_BIT;
			zero_ff <= `AXRJ_RST_BIT;
			sign_ff <= `AXRJ_RST_BIT;
			parity_ff <= `AXRJ_RST_BIT;
			done_ff <= `AXRJ_RST_BIT;
		end
		else
		begin
			state_ff <= nxt_state;
			ir_ff <= nxt_ir;
			pc_ff <= nxt_pc;
			addr_ff <= nxt_addr;
			mem_req_ff <= nxt_mem_req;
			jlo_ff <= nxt_jlo;
			carry_ff <= nxt_carry;
			zero_ff <= nxt_zero;
			sign_ff <= nxt_sign;
			parity_ff <= nxt_parity;
			done_ff <= nxt_done;
		end
	end

	// Execution owns the accumulator in its write cycle, so a preload there is lost.
	genvar gi;
	generate
		for (gi = 0; gi < `AXRJ_NUM_REGS; gi = gi + 1)
		begin : g_rf
			always @(posedge CLK_SYS)
			begin
				if (!NRST)
				begin
					rf_ff[gi] <= `AXRJ_RST_BYTE;
				end
				else if ((gi == 0) && acc_we)
				begin
					rf_ff[gi] <= acc_wdata;
				end
				else if (REG_WR_EN && (REG_WR_SEL == gi))
				begin
					rf_ff[gi] <= REG_WR_DATA;
				end
			end
		end
	endgenerate

	// Every output is a flip-flop, so nothing combinational reaches the pins.
	assign MEM_REQ = mem_req_ff;
	assign MEM_ADDR = addr_ff;
	assign PC = pc_ff;
	assign ACC = rf_ff[`AXRJ_IDX_ACC];
	assign FLAG_CARRY = carry_ff;
	assign FLAG_ZERO = zero_ff;
	assign FLAG_SIGN = sign_ff;
	assign FLAG_PARITY = parity_ff;
	assign INSTR_DONE = done_ff;
endmodule

// ---- sim/axrj_props.sv ----
// Purpose: Checker for the logic, rotate and jump core.
// Assumes: The first word acked after reset or a done pulse is the opcode.
// Notes: A preload between fetch and done would spoil the captured values.
`timescale 1ns/1ps
module axrj_props #(
	parameter PAGE_W = 6
)
(
	input wire CLK_SYS,
	input wire NRST,
	input wire [7:0] MEM_RDATA,
	input wire MEM_ACK,
	input wire MEM_REQ,
	input wire [PAGE_W+7:0] MEM_ADDR,
	input wire [PAGE_W+7:0] PC,
	input wire [7:0] ACC,
	input wire FLAG_CARRY,
	input wire FLAG_ZERO,
	input wire FLAG_SIGN,
	input wire FLAG_PARITY,
	input wire INSTR_DONE
);
	reg fetch_ff;
	reg [7:0] op_ff;
	reg [7:0] a_ff;
	reg [7:0] d0_ff;
	reg [7:0] d1_ff;
	reg [3:0] f_ff;
	reg [PAGE_W+7:0] pc_ff;
	wire dn = INSTR_DONE;
	wire rot = op_ff[7:5] == 3'h0 && op_ff[2:0] == 3'h2;
	wire grp = op_ff[5:4] == 2'h2 || op_ff[5:3] == 3'h6;
	wire imm = grp && op_ff[7:6] == 2'h0 && op_ff[2:0] == 3'h4;
	wire lg = grp && (op_ff[7:6] == 2'h2 || imm);
	wire jump_always = op_ff[7:6] == 2'h1 && op_ff[2:0] == 3'h4;
	// The opcode is the read that follows reset or a done pulse.
	always @(posedge CLK_SYS)
	begin
		if (!NRST)
			fetch_ff <= 1'b1;
		else if (MEM_ACK && MEM_REQ)
		begin
			d0_ff <= MEM_RDATA;
			d1_ff <= d0_ff;
			fetch_ff <= 1'b0;
			if (fetch_ff || dn)
			begin
				op_ff <= MEM_RDATA;
				a_ff <= ACC;
				f_ff <= {FLAG_CARRY, FLAG_ZERO, FLAG_SIGN, FLAG_PARITY};
				pc_ff <= MEM_ADDR;
			end
		end
		else if (dn)
			fetch_ff <= 1'b1;
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	a_rlc_res: assert property (dn && op_ff == 8'h02
		|-> ACC == {a_ff[6:0], a_ff[7]} && FLAG_CARRY == a_ff[7]) else $error("rlc wrong");
	a_ral_res: assert property (dn && op_ff == 8'h12
		|-> ACC == {a_ff[6:0], f_ff[3]} && FLAG_CARRY == a_ff[7]) else $error("ral wrong");
	a_rrc_res: assert property (dn && op_ff == 8'h0a
		|-> ACC == {a_ff[0], a_ff[7:1]} && FLAG_CARRY == a_ff[0]) else $error("rrc wrong");
	a_rar_res: assert property (dn && op_ff == 8'h1a
		|-> ACC == {f_ff[3], a_ff[7:1]} && FLAG_CARRY == a_ff[0]) else $error("rar wrong");
	a_rot_flags: assert property (dn && rot
		|-> {FLAG_ZERO, FLAG_SIGN, FLAG_PARITY} == f_ff[2:0]) else $error("rotate flags");
	a_logic_flags: assert property (dn && lg |-> !FLAG_CARRY && FLAG_SIGN == ACC[7]
		&& FLAG_ZERO == (ACC == 8'h00) && FLAG_PARITY == ~^ACC) else $error("logic flags");
	a_pc_step: assert property (dn && !jump_always
		|-> PC == pc_ff + (imm ? 2 : 1)) else $error("pc step wrong");
	a_jmp_target: assert property (dn && jump_always |-> ##0 MEM_REQ
		&& PC == {d0_ff[PAGE_W-1:0], d1_ff} && MEM_ADDR == PC) else $error("jump target");
	c_jump: cover property (dn && jump_always);
	c_imm: cover property (dn && imm);
	c_rot: cover property (dn && rot);
endmodule
bind axrj_core axrj_props #(.PAGE_W(PAGE_W)) u_props (.CLK_SYS(CLK_SYS), .NRST(NRST),
	.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
	.PC(PC), .ACC(ACC), .FLAG_CARRY(FLAG_CARRY), .FLAG_ZERO(FLAG_ZERO),
	.FLAG_SIGN(FLAG_SIGN), .FLAG_PARITY(FLAG_PARITY), .INSTR_DONE(INSTR_DONE));

// ---- sim/axrj_mem_model.sv ----
// Purpose: Program and data memory answering the core's read requests.
// Assumes: One read at a time, held by the core until acked.
// Notes: Read data is scrambled outside the ack cycle so stale data never looks valid.
`timescale 1ns/1ps
module axrj_mem_model
(
	input wire clk,
	input wire req,
	input wire [13:0] addr,
	input wire [3:0] lat,
	output reg [7:0] rdata,
	output reg ack
);
	reg [7:0] mem [0:16383];
	reg [3:0] wait_ff;
	integer i;
	initial
	begin
		ack = 1'b0;
		rdata = 8'h00;
		wait_ff = 4'h0;
		for (i = 0; i < 16384; i = i + 1)
			mem[i] = 8'hc0;
	end
	always @(posedge clk)
	begin
		rdata <= ~rdata;
		if (ack || !req)
		begin
			ack <= 1'b0;
			wait_ff <= 4'h0;
		end
		else if (wait_ff == lat)
		begin
			ack <= 1'b1;
			rdata <= mem[addr];
		end
		else
			wait_ff <= wait_ff + 4'h1;
	end
endmodule

// ---- sim/axrj_core_bench.sv ----
// Purpose: Self-checking bench for the logic, rotate and jump core.
// Assumes: Preloads land before the slow first fetch is acked.
// Notes: Each row runs one instruction from reset; a short program follows.
`timescale 1ns/1ps
module axrj_core_bench;
	typedef struct packed {logic [7:0] op; logic [7:0] a; logic [7:0] ea; logic ec;} axrj_row_t;
	axrj_row_t rows [16] = '{
		'{8'ha8, 8'haa, 8'h00, 1'b0}, '{8'ha9, 8'haa, 8'h66, 1'b0},
		'{8'haa, 8'haa, 8'h66, 1'b0}, '{8'hab, 8'haa, 8'h66, 1'b0},
		'{8'hac, 8'haa, 8'h66, 1'b0}, '{8'had, 8'haa, 8'h66, 1'b0},
		'{8'hae, 8'haa, 8'h66, 1'b0}, '{8'haf, 8'haa, 8'h66, 1'b0},
		'{8'h2c, 8'haa, 8'h66, 1'b0}, '{8'ha0, 8'haa, 8'haa, 1'b0},
		'{8'hb0, 8'haa, 8'haa, 1'b0}, '{8'h02, 8'h81, 8'h03, 1'b1},
		'{8'h12, 8'h81, 8'h02, 1'b1}, '{8'h0a, 8'h81, 8'hc0, 1'b1},
		'{8'h1a, 8'h81, 8'h40, 1'b1}, '{8'h02, 8'h00, 8'h00, 1'b0}};
	logic [7:0] prog [8] = '{8'h02, 8'h1a, 8'h12, 8'h2c, 8'hff, 8'h7c, 8'h10, 8'hc2};
	axrj_row_t r;
	logic [3:0] ef;
	reg CLK_SYS = 1'b0;
	reg NRST = 1'b0;
	reg REG_WR_EN = 1'b0;
	reg [2:0] REG_WR_SEL = 3'h0;
	reg [7:0] REG_WR_DATA = 8'h00;
	reg [3:0] lat = 4'h6;
	wire [7:0] MEM_RDATA;
	wire [7:0] ACC;
	wire [13:0] MEM_ADDR, PC;
	wire MEM_ACK, MEM_REQ, FLAG_CARRY, FLAG_ZERO, FLAG_SIGN, FLAG_PARITY, INSTR_DONE;
	integer mismatches = 0;
	integer check_count = 0;
	integer cycles = 0;
	integer i;
	axrj_core u_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
		.REG_WR_EN(REG_WR_EN), .REG_WR_SEL(REG_WR_SEL), .REG_WR_DATA(REG_WR_DATA),
		.MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .PC(PC), .ACC(ACC), .FLAG_CARRY(FLAG_CARRY),
		.FLAG_ZERO(FLAG_ZERO), .FLAG_SIGN(FLAG_SIGN), .FLAG_PARITY(FLAG_PARITY),
		.INSTR_DONE(INSTR_DONE));
	axrj_mem_model u_mem (.clk(CLK_SYS), .req(MEM_REQ), .addr(MEM_ADDR), .lat(lat),
		.rdata(MEM_RDATA), .ack(MEM_ACK));
	always #20 CLK_SYS = ~CLK_SYS;
	task final_report;
	begin
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// A hung handshake would otherwise stall the run for ever.
	always @(posedge CLK_SYS)
	begin
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			mismatches = mismatches + 1;
			final_report;
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
		end
	end
	endtask
	task do_reset;
	begin
		@(posedge CLK_SYS);
		NRST <= 1'b0;
		repeat (6) @(posedge CLK_SYS);
		check({PC, ACC, MEM_REQ, INSTR_DONE, FLAG_CARRY, FLAG_ZERO}, 32'h0, "reset");
		NRST <= 1'b1;
	end
	endtask
	task preload(input logic [2:0] sel, input logic [7:0] val);
	begin
		@(posedge CLK_SYS);
		REG_WR_EN <= 1'b1;
		REG_WR_SEL <= sel;
		REG_WR_DATA <= val;
	end
	endtask
	// The done pulse stands one cycle, so results are read in that same cycle.
	task step(input logic [7:0] ea, input logic [3:0] fl, input logic [13:0] epc);
	begin
		@(negedge CLK_SYS);
		while (INSTR_DONE !== 1'b1)
			@(negedge CLK_SYS);
		check(ACC, ea, "acc");
		check({FLAG_CARRY, FLAG_ZERO, FLAG_SIGN, FLAG_PARITY}, fl, "flags");
		check({MEM_REQ, MEM_ADDR, PC}, {1'b1, epc, epc}, "pc");
	end
	endtask
	initial
	begin
		#1;
		u_mem.mem[1] = 8'hcc;
		u_mem.mem[14'h0120] = 8'hcc;
		for (i = 0; i < 16; i = i + 1)
		begin
			r = rows[i];
			u_mem.mem[0] = r.op;
			ef = {r.ec, r.ea == 8'h00, r.ea[7], ~^r.ea};
			if (r.op[7:5] == 3'h0 && r.op[2:0] == 3'h2)
				ef = {r.ec, 3'h0};
			do_reset;
			preload(3'h5, 8'h01);
			preload(3'h6, 8'h20);
			preload(3'h0, r.a);
			preload(r.op[2:0], r.op[2:0] == 3'h0 ? r.a : 8'hcc);
			@(posedge CLK_SYS);
			REG_WR_EN <= 1'b0;
			step(r.ea, ef, r.op == 8'h2c ? 14'h2 : 14'h1);
			$display("row %0d done", i);
		end
		lat <= 4'h0;
		for (i = 0; i < 8; i = i + 1)
			u_mem.mem[i] = prog[i];
		u_mem.mem[14'h0210] = 8'h0a;
		u_mem.mem[14'h0211] = 8'ha9;
		u_mem.mem[14'h0212] = 8'ha9;
		do_reset;
		preload(3'h0, 8'h80);
		preload(3'h1, 8'h5a);
		@(posedge CLK_SYS);
		REG_WR_EN <= 1'b0;
		step(8'h01, 4'h8, 14'h1);
		step(8'h80, 4'h8, 14'h2);
		step(8'h01, 4'h8, 14'h3);
		step(8'hfe, 4'h2, 14'h5);
		step(8'hfe, 4'h2, 14'h0210);
		step(8'h7f, 4'h2, 14'h0211);
		step(8'h25, 4'h0, 14'h0212);
		step(8'h7f, 4'h0, 14'h0213);
		$display("program test done");
		final_report;
	end
endmodule
